// File: rtl/rx_framing_defines.vh
// constants for the receive bit framing and collision status block
`ifndef RX_FRAMING_DEFINES_VH
`define RX_FRAMING_DEFINES_VH
`define ADDR_STATE_STATUS     8'h0b
`define ADDR_RX_BIT_CONTROL   8'h0c
`define ADDR_RX_COLL_POS      8'h0d
`define BIT_KEEP_AFTER_COLL   7
`define FLD_FIRST_POS_HI      6
`define FLD_FIRST_POS_LO      4
`define BIT_COLL_AS_INTEG     3
`define FLD_FINAL_BITS_HI     2
`define FLD_FINAL_BITS_LO     0
`define BIT_POS_VALID         7
`define RX_BIT_CONTROL_RESET  8'h00
`define ST_IDLE               3'h0
`define ST_TX_PRE_WAIT        3'h1
`define ST_TRANSMIT           3'h3
`define ST_RX_PRE_WAIT        3'h5
`define ST_WAIT_DATA          3'h6
`define ST_RECEIVE            3'h7
`define COLL_INDEX_LIMIT      8'h40
`define RX_PRE_WAIT_CYCLES    8'h04
`endif

// File: rtl/rx_bit_packer.v
// places received data bits into bytes starting at a chosen bit position
`timescale 1ns/1ps
`include "rx_framing_defines.vh"
module rx_bit_packer (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       start_i,
  input  wire [2:0] first_pos_i,
  input  wire       bit_valid_i,
  input  wire       bit_i,
  input  wire       flush_i,
  output reg  [7:0] byte_o,
  output reg        byte_valid_o,
  output reg  [2:0] fill_o
);
  reg [7:0] acc_reg;
  reg [2:0] pos_reg;
  reg       any_reg;
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_reg      <= 8'h00;
      pos_reg      <= 3'h0;
      any_reg      <= 1'b0;
      byte_o       <= 8'h00;
      byte_valid_o <= 1'b0;
      fill_o       <= 3'h0;
    end else begin
      byte_valid_o <= 1'b0;
      if (start_i) begin
        acc_reg <= 8'h00;
        pos_reg <= first_pos_i;
        any_reg <= 1'b0;
      end else if (bit_valid_i) begin
        any_reg <= 1'b1;
        pos_reg <= pos_reg + 3'h1;
        if (pos_reg == 3'h7) begin
          // byte complete; next bit wraps to position zero of the next byte
          byte_o       <= {bit_i, acc_reg[6:0]};
          byte_valid_o <= 1'b1;
          acc_reg      <= 8'h00;
          fill_o       <= 3'h0;
        end else begin
          acc_reg[pos_reg] <= bit_i;
          fill_o           <= pos_reg + 3'h1;
        end
      end else if (flush_i && any_reg && pos_reg != 3'h0) begin
        byte_o       <= acc_reg;
        byte_valid_o <= 1'b1;
        acc_reg      <= 8'h00;
      end
    end
  end
endmodule

// File: rtl/rx_bit_framing_collision_status.v
// receive framing, collision capture and transceiver state reporting
`timescale 1ns/1ps
`include "rx_framing_defines.vh"
module rx_bit_framing_collision_status (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire [7:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       cmd_receive_i,
  input  wire       cmd_transceive_i,
  input  wire       tx_done_i,
  input  wire       sof_i,
  input  wire       bit_valid_i,
  input  wire       bit_i,
  input  wire       bit_coll_i,
  input  wire       parity_err_i,
  input  wire       frame_end_i,
  output reg  [7:0] reg_rdata_o,
  output reg  [7:0] rx_byte_o,
  output reg        rx_byte_valid_o,
  output reg        collision_flag_o,
  output reg        integrity_error_flag_o,
  output reg  [2:0] link_state_code_o
);
  localparam [7:0] CTRL_RESET = `RX_BIT_CONTROL_RESET;
  reg [2:0] state_reg;
  reg [7:0] wait_cnt_reg;
  reg       keep_bits_after_collision_reg;
  reg [2:0] rx_first_bit_position_reg;
  reg       collision_as_integrity_error_reg;
  reg [2:0] rx_final_valid_bits_reg;
  reg [6:0] first_collision_index_reg;
  reg       collision_position_valid_reg;
  reg       coll_seen_reg;
  reg [7:0] bit_index_reg;
  reg       recv_op_reg;
  wire      rx_start;
  wire      data_bit;
  wire      stored_bit;
  wire [7:0] pk_byte;
  wire      pk_valid;
  wire [2:0] pk_fill;
  wire      bit_oriented;
  reg [2:0] state_next;
  // flag clear point: wait-for-data entry only, reached after either command
  assign rx_start     = (state_reg != `ST_WAIT_DATA) && (state_next == `ST_WAIT_DATA);
  assign data_bit     = (state_reg == `ST_RECEIVE) && bit_valid_i;
  assign bit_oriented = (rx_first_bit_position_reg != 3'h0);
  // from the first collided bit on, zero the stored bit unless asked to keep it
  assign stored_bit   = (!keep_bits_after_collision_reg && (coll_seen_reg || bit_coll_i))
                        ? 1'b0 : bit_i;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `ST_IDLE: begin
        if (cmd_receive_i)
          state_next = `ST_RX_PRE_WAIT;
        else if (cmd_transceive_i)
          state_next = `ST_TX_PRE_WAIT;
      end
      `ST_TX_PRE_WAIT: begin
        if (wait_cnt_reg == 8'h00)
          state_next = `ST_TRANSMIT;
      end
      `ST_TRANSMIT: begin
        if (tx_done_i)
          state_next = `ST_RX_PRE_WAIT;
      end
      `ST_RX_PRE_WAIT: begin
        if (wait_cnt_reg == 8'h00)
          state_next = `ST_WAIT_DATA;
      end
      `ST_WAIT_DATA: begin
        if (sof_i)
          state_next = `ST_RECEIVE;
      end
      `ST_RECEIVE: begin
        if (frame_end_i)
          state_next = `ST_IDLE;
      end
      default: state_next = `ST_IDLE;
    endcase
  end

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg         <= `ST_IDLE;
      wait_cnt_reg      <= 8'h00;
      link_state_code_o <= `ST_IDLE;
      recv_op_reg       <= 1'b0;
    end else begin
      state_reg         <= state_next;
      link_state_code_o <= state_next;
      if (state_next != state_reg)
        wait_cnt_reg <= `RX_PRE_WAIT_CYCLES;
      else if (wait_cnt_reg != 8'h00)
        wait_cnt_reg <= wait_cnt_reg - 8'h01;
      if (state_reg == `ST_IDLE)
        recv_op_reg <= cmd_receive_i;
    end
  end

  // control register: host writes steer framing; final-bits is set by hardware
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      keep_bits_after_collision_reg    <= CTRL_RESET[`BIT_KEEP_AFTER_COLL];
      rx_first_bit_position_reg        <= 3'h0;
      collision_as_integrity_error_reg <= 1'b0;
      rx_final_valid_bits_reg          <= 3'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `ADDR_RX_BIT_CONTROL) begin
        keep_bits_after_collision_reg    <= reg_wdata_i[`BIT_KEEP_AFTER_COLL];
        rx_first_bit_position_reg        <= reg_wdata_i[`FLD_FIRST_POS_HI:`FLD_FIRST_POS_LO];
        collision_as_integrity_error_reg <= reg_wdata_i[`BIT_COLL_AS_INTEG];
        rx_final_valid_bits_reg          <= reg_wdata_i[`FLD_FINAL_BITS_HI:`FLD_FINAL_BITS_LO];
      end
      // hardware update wins over a host write in the same cycle
      if (rx_start)
        rx_final_valid_bits_reg <= 3'h0;
      else if (state_reg == `ST_RECEIVE && frame_end_i && bit_oriented)
        rx_final_valid_bits_reg <= pk_fill;
    end
  end

  // collision capture; the start clear wins over detection sets
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      coll_seen_reg                <= 1'b0;
      bit_index_reg                <= 8'h00;
      first_collision_index_reg    <= 7'h00;
      collision_position_valid_reg <= 1'b0;
      collision_flag_o             <= 1'b0;
      integrity_error_flag_o       <= 1'b0;
    end else begin
      if (rx_start) begin
        coll_seen_reg                <= 1'b0;
        bit_index_reg                <= {5'h00, rx_first_bit_position_reg};
        first_collision_index_reg    <= 7'h00;
        collision_position_valid_reg <= 1'b0;
        collision_flag_o             <= 1'b0;
        integrity_error_flag_o       <= 1'b0;
      end else if (data_bit) begin
        // index counts data bits only; it saturates past the indexable range
        if (bit_index_reg != 8'hff)
          bit_index_reg <= bit_index_reg + 8'h01;
        if (bit_coll_i && !coll_seen_reg) begin
          coll_seen_reg    <= 1'b1;
          collision_flag_o <= 1'b1;
          if (bit_index_reg < `COLL_INDEX_LIMIT) begin
            first_collision_index_reg    <= bit_index_reg[6:0];
            collision_position_valid_reg <= 1'b1;
          end
        end
        if (parity_err_i || (bit_coll_i && collision_as_integrity_error_reg))
          integrity_error_flag_o <= 1'b1;
      end
    end
  end

  rx_bit_packer u_packer (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .start_i      (rx_start),
    .first_pos_i  (rx_first_bit_position_reg),
    .bit_valid_i  (data_bit),
    .bit_i        (stored_bit),
    .flush_i      (state_reg == `ST_RECEIVE && frame_end_i),
    .byte_o       (pk_byte),
    .byte_valid_o (pk_valid),
    .fill_o       (pk_fill)
  );

  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_byte_o       <= 8'h00;
      rx_byte_valid_o <= 1'b0;
      reg_rdata_o     <= 8'h00;
    end else begin
      rx_byte_o       <= pk_byte;
      rx_byte_valid_o <= pk_valid;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `ADDR_STATE_STATUS:   reg_rdata_o <= {5'h00, state_reg};
          // final-bits field is write-only and reads as zero
          `ADDR_RX_BIT_CONTROL: reg_rdata_o <= {keep_bits_after_collision_reg,
                                                rx_first_bit_position_reg,
                                                collision_as_integrity_error_reg, 3'h0};
          `ADDR_RX_COLL_POS:    reg_rdata_o <= {collision_position_valid_reg,
                                                first_collision_index_reg};
          default:              reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule

// File: testbench/rx_framing_assertions.sv
// concurrent checks on the receive framing block ports
`timescale 1ns/1ps
`include "rx_framing_defines.vh"
module rx_framing_assertions (
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire       cmd_receive_i,
  input wire       cmd_transceive_i,
  input wire       tx_done_i,
  input wire       sof_i,
  input wire       bit_valid_i,
  input wire       bit_coll_i,
  input wire       frame_end_i,
  input wire       collision_flag_o,
  input wire       integrity_error_flag_o,
  input wire [2:0] link_state_code_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_no_unused_code: assert property (link_state_code_o != 3'h4)
    else $error("unused state code shown");
  a_rx_cmd_start: assert property (link_state_code_o == `ST_IDLE && cmd_receive_i
    |=> link_state_code_o == `ST_RX_PRE_WAIT) else $error("receive did not start");
  a_tx_cmd_start: assert property (link_state_code_o == `ST_IDLE && cmd_transceive_i
    && !cmd_receive_i |=> link_state_code_o == `ST_TX_PRE_WAIT) else $error("no tx wait");
  a_pre_wait_len: assert property (link_state_code_o == 3'h5 && $past(link_state_code_o) != 3'h5
    |-> (link_state_code_o == 3'h5) [*5] ##1 link_state_code_o == 3'h6) else $error("rx wait len");
  a_tx_to_rx: assert property (link_state_code_o == `ST_TRANSMIT && tx_done_i
    |=> link_state_code_o == `ST_RX_PRE_WAIT) else $error("tx done ignored");
  a_sof_enter: assert property (link_state_code_o == `ST_WAIT_DATA && sof_i
    |=> link_state_code_o == `ST_RECEIVE) else $error("frame start ignored");
  a_frame_close: assert property (link_state_code_o == `ST_RECEIVE && frame_end_i
    |=> link_state_code_o == `ST_IDLE) else $error("frame end ignored");
  a_wait_clears: assert property (link_state_code_o == 3'h6 && $past(link_state_code_o) != 3'h6
    |-> !collision_flag_o && !integrity_error_flag_o) else $error("flags not cleared");
  a_coll_sets: assert property (link_state_code_o == `ST_RECEIVE && bit_valid_i && bit_coll_i
    |=> collision_flag_o) else $error("collision not flagged");
  a_flag_drop: assert property ($fell(collision_flag_o) |-> link_state_code_o == 3'h6)
    else $error("collision flag dropped early");
endmodule
bind rx_bit_framing_collision_status rx_framing_assertions u_rx_framing_assertions (.*);

// File: testbench/tag_model.sv
// behavioural far-side tag: ends transmission and answers with a bit frame
`timescale 1ns/1ps
module tag_model (
  input  wire logic clk_i,
  output logic      tx_done_o,
  output logic      sof_o,
  output logic      bit_valid_o,
  output logic      bit_o,
  output logic      bit_coll_o,
  output logic      parity_err_o,
  output logic      frame_end_o
);
  // parity faults are never produced, so integrity errors come from collisions only
  initial {tx_done_o, sof_o, bit_valid_o, bit_o, bit_coll_o, parity_err_o, frame_end_o} = 7'h00;
  task automatic finish_tx();
    @(negedge clk_i);
    tx_done_o = 1'b1;
    @(negedge clk_i);
    tx_done_o = 1'b0;
  endtask
  // between bits the data line shows the inverse so a stale value cannot pass
  task automatic reply(input logic [15:0] b, input logic [15:0] c, input int n);
    int k;
    sof_o = 1'b1;
    @(negedge clk_i);
    sof_o = 1'b0;
    for (k = 0; k < n; k++) begin
      bit_o = b[k];
      bit_coll_o = c[k];
      bit_valid_o = 1'b1;
      @(negedge clk_i);
      bit_valid_o = 1'b0;
      bit_o = ~b[k];
      bit_coll_o = 1'b0;
      @(negedge clk_i);
    end
    frame_end_o = 1'b1;
    @(negedge clk_i);
    frame_end_o = 1'b0;
  endtask
endmodule

// File: testbench/rx_bit_framing_collision_status_tb.sv
// self-checking bench for the receive framing and collision status block
`timescale 1ns/1ps
`include "rx_framing_defines.vh"
module rx_bit_framing_collision_status_tb;
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       cmd_receive_i = 1'b0;
  logic       cmd_transceive_i = 1'b0;
  wire        tx_done_i, sof_i, bit_valid_i, bit_i, bit_coll_i, parity_err_i, frame_end_i;
  wire  [7:0] reg_rdata_o, rx_byte_o;
  wire        rx_byte_valid_o, collision_flag_o, integrity_error_flag_o;
  wire  [2:0] link_state_code_o;
  logic [7:0] rxb [4];
  int         nb, fails, n_checks;
  rx_bit_framing_collision_status u_rx_bit_framing_collision_status (.*);
  tag_model u_tag_model (.clk_i(clk_i), .tx_done_o(tx_done_i), .sof_o(sof_i),
    .bit_valid_o(bit_valid_i), .bit_o(bit_i), .bit_coll_o(bit_coll_i),
    .parity_err_o(parity_err_i), .frame_end_o(frame_end_i));
  initial forever #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (rx_byte_valid_o === 1'b1 && nb < 4) begin
    rxb[nb] <= rx_byte_o;
    nb <= nb + 1;
  end
  task automatic wrap_up();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  // read data is registered, so it is looked at one edge after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask
  task automatic wait_st(input logic [2:0] s);
    int i;
    for (i = 0; i < 60 && link_state_code_o !== s; i++)
      @(negedge clk_i);
    if (i == 60) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic run(input logic [7:0] ctrl, input logic tx, input logic [15:0] b,
                     input logic [15:0] c, input int n);
    wr(`ADDR_RX_BIT_CONTROL, ctrl);
    nb = 0;
    cmd_receive_i = !tx;
    cmd_transceive_i = tx;
    @(negedge clk_i);
    cmd_receive_i = 1'b0;
    cmd_transceive_i = 1'b0;
    if (tx) begin
      wait_st(`ST_TRANSMIT);
      u_tag_model.finish_tx();
    end
    wait_st(`ST_WAIT_DATA);
    rd(`ADDR_STATE_STATUS, {5'h00, `ST_WAIT_DATA});
    chk({6'h00, collision_flag_o, integrity_error_flag_o}, 8'h00);
    u_tag_model.reply(b, c, n);
    wait_st(`ST_IDLE);
    repeat (3) @(negedge clk_i);
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    sys_rst_i = 1'b0;
    rd(`ADDR_STATE_STATUS, 8'h00);
    rd(`ADDR_RX_COLL_POS, 8'h00);
    rd(8'h20, 8'h00);
    wr(`ADDR_RX_BIT_CONTROL, 8'hff);
    rd(`ADDR_RX_BIT_CONTROL, 8'hf8);
    wr(`ADDR_RX_COLL_POS, 8'h5a);
    rd(`ADDR_RX_COLL_POS, 8'h00);
    // start at bit 4, zero after collision, collision counts as integrity error
    run(8'h48, 1'b0, 16'h00ff, 16'h0008, 8);
    chk(rxb[0] & 8'hf0, 8'h70);
    chk(rxb[1], 8'h00);
    chk(8'(nb), 8'h02);
    chk({6'h00, collision_flag_o, integrity_error_flag_o}, 8'h03);
    rd(`ADDR_RX_COLL_POS, 8'h87);
    run(8'h80, 1'b1, 16'h00a5, 16'h0000, 8);
    chk(rxb[0], 8'ha5);
    chk(8'(nb), 8'h01);
    chk({6'h00, collision_flag_o, integrity_error_flag_o}, 8'h00);
    rd(`ADDR_RX_COLL_POS, 8'h00);
    // start at the top bit with bits kept; collision on the second bit
    run(8'hf0, 1'b0, 16'h0003, 16'h0002, 2);
    chk(rxb[0] & 8'h80, 8'h80);
    chk(rxb[1] & 8'h01, 8'h01);
    chk({6'h00, collision_flag_o, integrity_error_flag_o}, 8'h02);
    rd(`ADDR_RX_COLL_POS, 8'h88);
    wrap_up();
  end
endmodule
